// ==== core/fio_ports.sv ====
/*
  Two 4-bit general-purpose I/O ports behind an APB slave. Holds output
  latches, direction, pull-up and function registers, pin-read masking,
  secondary input feeds and the oscillator-enable guard reset.
  Assumes pins and the oscillator enable are synchronous to clk.
*/
// Implementation choice: register access over APB.
module fio_ports #(
  parameter int ADDR_W = 16
) (
  input wire logic clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port zero pins
  input wire logic [3:0] p0PinIn,
  output logic [3:0] p0PinOut,
  output logic [3:0] p0PinOe,
  output logic [3:0] p0PullupOn,
  // Port one pins
  input wire logic [3:0] p1PinIn,
  output logic [3:0] p1PinOut,
  output logic [3:0] p1PinOe,
  output logic [3:0] p1PullupOn,
  // Oscillator connection selects to the clock generator
  output logic hfOscPinSelect,
  output logic lfOscPinSelect,
  input wire logic externalHfOscEnable,
  output logic sysClkResetReq,
  // Secondary input feeds
  output logic extIrqZero,
  output logic extIrqOne,
  output logic extIrqFive,
  output logic stopReleaseIn,
  output logic extResetIn,
  output logic resetPinMode
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (ADDR_W < 14 || ADDR_W > 32) begin : g_bad_addr
    $error("fio_ports needs ADDR_W between 14 and 32");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] p0Latch; // Port zero output latch
    logic [3:0] p1Latch; // Port one output latch
    logic [3:0] p0Dir; // Port zero direction
    logic [3:0] p1Dir; // Port one direction
    logic [3:0] port_zero_pullup_enable; // Port zero pull-up enables
    logic [3:0] port_one_pullup_enable; // Port one pull-up enables
    logic hfSel; // Pins 0,1 given to HF oscillator
    logic lfSel; // Pins 2,3 given to LF oscillator
    logic rstPin; // Port one pin 0 serves as reset input
    logic [7:0] rdata; // Read data captured in setup phase
    logic xenPrev; // Oscillator enable, previous cycle
    logic rstReq; // Guard reset pulse
    logic [3:0] irq; // {stop/irq5, irq0, irq1, extreset} feeds
  } fio_state_t;

  fio_state_t state_q;
  fio_state_t state_d;

  // Pin controller results
  logic [3:0] p0Func;
  logic [3:0] p1Func;
  logic [3:0] p0Read;
  logic [3:0] p1Read;

  // Bus decode
  logic setupPh;
  logic accessPh;
  logic wrEn;
  logic hit;

  // ----------------------------------------------------------------
  // Address decode helper
  // ----------------------------------------------------------------
  // True when the byte address selects the register of this index
  function automatic logic regHit(input logic [ADDR_W-1:0] a,
                                  input logic [15:0] idx);
    logic [31:0] byteAddr;
    byteAddr = {14'h0000, idx, 2'b00};
    regHit = ({{(32-ADDR_W){1'b0}}, a} == byteAddr);
  endfunction

  // True when the address selects any register of this block
  function automatic logic anyHit(input logic [ADDR_W-1:0] a);
    anyHit = regHit(a, fio_pkg::P0_LATCH_IDX) |
             regHit(a, fio_pkg::P1_LATCH_IDX) |
             regHit(a, fio_pkg::P0_READ_IDX) |
             regHit(a, fio_pkg::P1_READ_IDX) |
             regHit(a, fio_pkg::P0_DIR_IDX) |
             regHit(a, fio_pkg::P1_DIR_IDX) |
             regHit(a, fio_pkg::P0_PU_IDX) |
             regHit(a, fio_pkg::P1_PU_IDX) |
             regHit(a, fio_pkg::P0_FUNC_IDX) |
             regHit(a, fio_pkg::P1_RSTCTL_IDX);
  endfunction

  // ----------------------------------------------------------------
  // Pin controllers
  // ----------------------------------------------------------------
  // Oscillator functions take pin pairs away from the port
  assign p0Func = {state_q.lfSel, state_q.lfSel,
                   state_q.hfSel, state_q.hfSel};
  // Reset-input function takes port one pin 0 away from the driver
  assign p1Func = {3'b000, state_q.rstPin};

  // Port zero
  fio_pin_ctl #(.WIDTH(4)) u_port_zero (
    .latchVal(state_q.p0Latch),
    .dirVal(state_q.p0Dir),
    .pullVal(state_q.port_zero_pullup_enable),
    .funcMask(p0Func),
    .pinIn(p0PinIn),
    .pinOut(p0PinOut),
    .pinOe(p0PinOe),
    .pullupOn(p0PullupOn),
    .readVal(p0Read)
  );

  // Port one; pin 0 reads and pulls up like any input
  fio_pin_ctl #(.WIDTH(4)) u_port_one (
    .latchVal(state_q.p1Latch),
    .dirVal(state_q.p1Dir),
    .pullVal(state_q.port_one_pullup_enable),
    .funcMask(4'h0),
    .pinIn(p1PinIn),
    .pinOut(p1PinOut),
    .pinOe(),
    .pullupOn(p1PullupOn),
    .readVal(p1Read)
  );

  // Driver enable of port one, with pin 0 held off in reset-input mode
  assign p1PinOe = state_q.p1Dir & ~p1Func;

  // ----------------------------------------------------------------
  // APB phases
  // ----------------------------------------------------------------
  assign setupPh = psel & ~penable;
  assign accessPh = psel & penable;
  assign hit = anyHit(paddr);
  assign wrEn = accessPh & pwrite & hit;

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = accessPh & ~hit;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    // Register writes take effect at the access edge
    if (wrEn) begin
      if (regHit(paddr, fio_pkg::P0_LATCH_IDX)) begin
        state_d.p0Latch = pwdata[3:0];
      end
      if (regHit(paddr, fio_pkg::P1_LATCH_IDX)) begin
        state_d.p1Latch = pwdata[3:0];
      end
      if (regHit(paddr, fio_pkg::P0_DIR_IDX)) begin
        state_d.p0Dir = pwdata[3:0];
      end
      if (regHit(paddr, fio_pkg::P1_DIR_IDX)) begin
        state_d.p1Dir = pwdata[3:0];
      end
      if (regHit(paddr, fio_pkg::P0_PU_IDX)) begin
        state_d.port_zero_pullup_enable = pwdata[3:0];
      end
      if (regHit(paddr, fio_pkg::P1_PU_IDX)) begin
        state_d.port_one_pullup_enable = pwdata[3:0];
      end
      if (regHit(paddr, fio_pkg::P0_FUNC_IDX)) begin
        state_d.hfSel = pwdata[fio_pkg::HF_SEL_BIT];
        state_d.lfSel = pwdata[fio_pkg::LF_SEL_BIT];
      end
      if (regHit(paddr, fio_pkg::P1_RSTCTL_IDX)) begin
        state_d.rstPin = pwdata[fio_pkg::RST_PIN_BIT];
      end
    end

    // Read data is captured in the setup phase, stable for access
    if (setupPh) begin
      state_d.rdata = 8'h00;
      if (regHit(paddr, fio_pkg::P0_LATCH_IDX)) begin
        state_d.rdata = {4'h0, state_q.p0Latch};
      end else if (regHit(paddr, fio_pkg::P1_LATCH_IDX)) begin
        state_d.rdata = {4'h0, state_q.p1Latch};
      end else if (regHit(paddr, fio_pkg::P0_READ_IDX)) begin
        state_d.rdata = {4'h0, p0Read};
      end else if (regHit(paddr, fio_pkg::P1_READ_IDX)) begin
        state_d.rdata = {4'h0, p1Read};
      end else if (regHit(paddr, fio_pkg::P0_DIR_IDX)) begin
        state_d.rdata = {4'h0, state_q.p0Dir};
      end else if (regHit(paddr, fio_pkg::P1_DIR_IDX)) begin
        state_d.rdata = {4'h0, state_q.p1Dir};
      end else if (regHit(paddr, fio_pkg::P0_PU_IDX)) begin
        state_d.rdata = {4'h0, state_q.port_zero_pullup_enable};
      end else if (regHit(paddr, fio_pkg::P1_PU_IDX)) begin
        state_d.rdata = {4'h0, state_q.port_one_pullup_enable};
      end else if (regHit(paddr, fio_pkg::P0_FUNC_IDX)) begin
        state_d.rdata = {5'h00, state_q.lfSel, 1'b0, state_q.hfSel};
      end else if (regHit(paddr, fio_pkg::P1_RSTCTL_IDX)) begin
        state_d.rdata = {7'h00, state_q.rstPin};
      end else begin
        // Unmapped address reads as zero
        state_d.rdata = 8'h00;
      end
    end

    // Oscillator enable rising without the pin function: guard reset
    state_d.xenPrev = externalHfOscEnable;
    state_d.rstReq = externalHfOscEnable & ~state_q.xenPrev &
                     ~state_q.hfSel;

    // Secondary feeds: pin level while input, idle high otherwise
    state_d.irq[3] = state_q.p1Dir[1] ? 1'b1 : p1PinIn[1];
    state_d.irq[2] = state_q.p1Dir[2] ? 1'b1 : p1PinIn[2];
    state_d.irq[1] = state_q.p1Dir[3] ? 1'b1 : p1PinIn[3];
    // Reset input follows pin 0 only in reset-input mode
    state_d.irq[0] = state_q.rstPin ? p1PinIn[0] : 1'b1;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q.p0Latch <= fio_pkg::LATCH_RST;
      state_q.p1Latch <= fio_pkg::LATCH_RST;
      state_q.p0Dir <= fio_pkg::DIR_RST;
      state_q.p1Dir <= fio_pkg::DIR_RST;
      state_q.port_zero_pullup_enable <= fio_pkg::PU_RST;
      state_q.port_one_pullup_enable <= fio_pkg::PU_RST;
      state_q.hfSel <= fio_pkg::FUNC_RST[0];
      state_q.lfSel <= fio_pkg::FUNC_RST[0];
      state_q.rstPin <= fio_pkg::RST_PIN_RST[0];
      state_q.rdata <= 8'h00;
      state_q.xenPrev <= 1'b0;
      state_q.rstReq <= 1'b0;
      state_q.irq <= fio_pkg::IRQ_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = {24'h00_0000, state_q.rdata};
  assign hfOscPinSelect = state_q.hfSel;
  assign lfOscPinSelect = state_q.lfSel;
  assign sysClkResetReq = state_q.rstReq;
  assign stopReleaseIn = state_q.irq[3];
  assign extIrqFive = state_q.irq[3];
  assign extIrqZero = state_q.irq[2];
  assign extIrqOne = state_q.irq[1];
  assign extResetIn = state_q.irq[0];
  assign resetPinMode = state_q.rstPin;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_dir_after_reset: assert property (@(posedge clk)
    $rose(resetn) |-> (state_q.p0Dir == 4'h0 && state_q.p1Dir == 4'h0))
    else $error("direction not cleared by reset");

  a_latch_write: assert property (@(posedge clk) disable iff (!resetn)
    (wrEn && regHit(paddr, fio_pkg::P0_LATCH_IDX)) |=>
    (p0PinOut == $past(pwdata[3:0])))
    else $error("port zero latch write lost");

  a_p1_latch_write: assert property (@(posedge clk) disable iff (!resetn)
    (wrEn && regHit(paddr, fio_pkg::P1_LATCH_IDX)) |=>
    (p1PinOut == $past(pwdata[3:0])))
    else $error("port one latch write lost");

  a_hf_guard_reset: assert property (@(posedge clk)
    disable iff (!resetn)
    (externalHfOscEnable && !state_q.xenPrev && !hfOscPinSelect) |=>
    sysClkResetReq ##1 !sysClkResetReq)
    else $error("oscillator guard reset not one pulse");

  a_no_guard_sel: assert property (@(posedge clk) disable iff (!resetn)
    hfOscPinSelect && $stable(hfOscPinSelect) |=> !sysClkResetReq)
    else $error("guard reset with pin function set");

  a_p0_pull_input: assert property (@(posedge clk)
    disable iff (!resetn)
    (p0PullupOn & (state_q.p0Dir | p0Func)) == 4'h0)
    else $error("port zero pull-up outside input mode");

  a_p1_pull_input: assert property (@(posedge clk)
    disable iff (!resetn)
    (p1PullupOn & (state_q.p1Dir | ~state_q.port_one_pullup_enable)) == 4'h0)
    else $error("port one pull-up wrongly connected");

  a_p0_read_mask: assert property (@(posedge clk)
    disable iff (!resetn)
    (setupPh && regHit(paddr, fio_pkg::P0_READ_IDX) && state_q.hfSel)
    ##1 (psel && penable) |-> prdata[1:0] == 2'b00)
    else $error("oscillator pins read nonzero");

  a_p0_read_lf: assert property (@(posedge clk)
    disable iff (!resetn)
    (setupPh && regHit(paddr, fio_pkg::P0_READ_IDX)) |=>
    ((prdata[3:2] & ($past(state_q.p0Dir[3:2]) |
      {2{$past(state_q.lfSel)}})) == 2'b00))
    else $error("pins 2,3 read nonzero when not inputs");

  a_p1_read_mask: assert property (@(posedge clk)
    disable iff (!resetn)
    (setupPh && regHit(paddr, fio_pkg::P1_READ_IDX)) |=>
    (prdata[31:4] == 28'h000_0000 &&
     prdata[3:0] == ($past(p1PinIn) & ~$past(state_q.p1Dir))))
    else $error("port one read value wrong");

  a_drive_only_out: assert property (@(posedge clk)
    disable iff (!resetn)
    ((p0PinOe & ~state_q.p0Dir) | (p0PinOe & p0Func) |
     (p1PinOe & ~state_q.p1Dir)) == 4'h0)
    else $error("pin driven outside output mode");

  a_rst_pin_held: assert property (@(posedge clk)
    disable iff (!resetn)
    // The release edge still loads reset values, so it is not judged
    (resetn && resetPinMode) |->
    (!p1PinOe[0] ##1 extResetIn == $past(p1PinIn[0])))
    else $error("reset pin not serving reset input");

  a_irq_feed: assert property (@(posedge clk)
    disable iff (!resetn)
    (resetn && !state_q.p1Dir[2] && $stable(state_q.p1Dir)) |=>
    extIrqZero == $past(p1PinIn[2]))
    else $error("interrupt zero not fed from pin");

endmodule

// ==== core/fio_pkg.sv ====
/*
  Constants for the two 4-bit general-purpose I/O ports: register indices,
  field positions and values after reset.
  Assumes an APB slave with 32-bit data, one aligned word per register.
*/
// Behaviour
// - Port zero has four independently directed pins
// - Port zero latch at index 0x0000, four bits
// - Function bit0 HF oscillator, bit2 LF oscillator
// - HF oscillator enable without pin function causes reset
// - Port zero pull-up only in plain input mode
// - Port one: four pins, interrupts, stop release, reset
// - Port one pin 0 is reset input after reset
// - Port one latch at index 0x0001, four bits
// - Port one input pins feed interrupt/stop functions
// - Port one pull-up only when input and enabled
package fio_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] P0_LATCH_IDX = 16'h0000;
  localparam logic [15:0] P1_LATCH_IDX = 16'h0001;
  localparam logic [15:0] P0_READ_IDX = 16'h000D;
  localparam logic [15:0] P1_READ_IDX = 16'h000E;
  localparam logic [15:0] P0_DIR_IDX = 16'h0F1A;
  localparam logic [15:0] P1_DIR_IDX = 16'h0F1B;
  localparam logic [15:0] P0_PU_IDX = 16'h0F27;
  localparam logic [15:0] P1_PU_IDX = 16'h0F28;
  localparam logic [15:0] P0_FUNC_IDX = 16'h0F34;
  localparam logic [15:0] P1_RSTCTL_IDX = 16'h0F3F;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int HF_SEL_BIT = 0;
  localparam int LF_SEL_BIT = 2;
  localparam int RST_PIN_BIT = 0;
  localparam int PORT_BITS = 4;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [3:0] LATCH_RST = 4'h0;
  localparam logic [3:0] DIR_RST = 4'h0;
  localparam logic [3:0] PU_RST = 4'h0;
  localparam logic [0:0] FUNC_RST = 1'h0;
  localparam logic [0:0] RST_PIN_RST = 1'h1;
  localparam logic [3:0] IRQ_IDLE = 4'hF;

endpackage

// ==== core/fio_pin_ctl.sv ====
/*
  Per-port pin control: output drive, driver enable, pull-up connection and
  pin-read masking for one port. Purely combinational from the registers.
  Assumes pin levels arrive synchronous to the system clock.
*/
module fio_pin_ctl #(
  parameter int WIDTH = 4
) (
  input wire logic [WIDTH-1:0] latchVal,
  input wire logic [WIDTH-1:0] dirVal,
  input wire logic [WIDTH-1:0] pullVal,
  input wire logic [WIDTH-1:0] funcMask,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut,
  output logic [WIDTH-1:0] pinOe,
  output logic [WIDTH-1:0] pullupOn,
  output logic [WIDTH-1:0] readVal
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (WIDTH < 1) begin : g_bad_width
    $error("fio_pin_ctl needs at least one bit");
  end

  // Plain port input: direction 0 and no secondary function taken
  logic [WIDTH-1:0] portIn;

  // ----------------------------------------------------------------
  // Pin behaviour
  // ----------------------------------------------------------------
  always_comb begin
    portIn = ~dirVal & ~funcMask;
    // Latch value is always presented; enable decides if it reaches pin
    pinOut = latchVal;
    pinOe = dirVal & ~funcMask;
    pullupOn = pullVal & portIn;
    readVal = pinIn & portIn;
  end

endmodule

// ==== tb/fio_pin_model.sv ====
/*
  Behavioural model of the four pads of one port and whatever hangs on them.
  Assumes the port's controls are synchronous to clk; pad level is registered.
*/
module fio_pin_model (
  input wire logic clk,
  input wire logic [3:0] pinOe,
  input wire logic [3:0] pinOut,
  input wire logic [3:0] pullupOn,
  input wire logic [3:0] extDrive,
  input wire logic [3:0] extEn,
  output logic [3:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Pad resolution
  // ---------------------------------------------------------------
  initial pinIn = 4'h0;

  // Device driver wins, then outside source, then pull-up, else floating
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (pinOe[i]) begin
        pinIn[i] <= pinOut[i];
      end else if (extEn[i]) begin
        pinIn[i] <= extDrive[i];
      end else if (pullupOn[i]) begin
        pinIn[i] <= 1'b1;
      end else begin
        pinIn[i] <= ~pinIn[i]; // Floating pad wanders every cycle
      end
    end
  end
endmodule

// ==== tb/fio_ports_tb.sv ====
/*
  Self-checking bench for the two-port I/O block: APB register traffic,
  pad behaviour, secondary input feeds and the oscillator guard reset.
  Assumes fio_pkg and fio_pin_model are compiled first.
*/
module fio_ports_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] p0PinIn, p0PinOut, p0PinOe, p0PullupOn;
  logic [3:0] p1PinIn, p1PinOut, p1PinOe, p1PullupOn;
  logic [3:0] p0Ext, p0ExtEn, p1Ext, p1ExtEn;
  logic hfOscPinSelect, lfOscPinSelect, externalHfOscEnable;
  logic sysClkResetReq, extIrqZero, extIrqOne, extIrqFive;
  logic stopReleaseIn, extResetIn, resetPinMode;
  int numErrors = 0; // Mismatch count
  int testsRun = 0; // Comparison count

  fio_ports #(.ADDR_W(16)) u_fio_ports (.clk(clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .p0PinIn(p0PinIn), .p0PinOut(p0PinOut), .p0PinOe(p0PinOe),
    .p0PullupOn(p0PullupOn), .p1PinIn(p1PinIn), .p1PinOut(p1PinOut),
    .p1PinOe(p1PinOe), .p1PullupOn(p1PullupOn),
    .hfOscPinSelect(hfOscPinSelect), .lfOscPinSelect(lfOscPinSelect),
    .externalHfOscEnable(externalHfOscEnable),
    .sysClkResetReq(sysClkResetReq), .extIrqZero(extIrqZero),
    .extIrqOne(extIrqOne), .extIrqFive(extIrqFive),
    .stopReleaseIn(stopReleaseIn), .extResetIn(extResetIn),
    .resetPinMode(resetPinMode));

  fio_pin_model u_pads0 (.clk(clk), .pinOe(p0PinOe), .pinOut(p0PinOut),
    .pullupOn(p0PullupOn), .extDrive(p0Ext), .extEn(p0ExtEn),
    .pinIn(p0PinIn));
  fio_pin_model u_pads1 (.clk(clk), .pinOe(p1PinOe), .pinOut(p1PinOut),
    .pullupOn(p1PullupOn), .extDrive(p1Ext), .extEn(p1ExtEn),
    .pinIn(p1PinIn));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  // Compare one value and count it
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      numErrors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= idx << 2;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, d, rd, err);
  endtask

  // Read a register and judge data and error response
  task automatic rchk(input string what, input logic [15:0] idx,
                      input logic [31:0] exp, input logic expErr);
    logic [31:0] rd;
    logic err;
    apb(1'b0, idx, 32'h0000_0000, rd, err);
    chk(what, exp, rd);
    chk({what, " err"}, {31'h0000_0000, expErr}, {31'h0000_0000, err});
  endtask

  // Let n edges pass, then sample settled outputs
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Raise the oscillator enable; watch the two following cycles
  task automatic osc_try(input logic expPulse);
    @(posedge clk);
    externalHfOscEnable <= 1'b1;
    tick(1);
    chk("guard reset", {31'h0, expPulse}, {31'h0, sysClkResetReq});
    tick(1);
    chk("guard reset end", 32'h0, {31'h0, sysClkResetReq});
    @(posedge clk);
    externalHfOscEnable <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    logic [15:0] idx [7];
    idx = '{fio_pkg::P0_LATCH_IDX, fio_pkg::P1_LATCH_IDX,
            fio_pkg::P0_DIR_IDX, fio_pkg::P1_DIR_IDX, fio_pkg::P0_PU_IDX,
            fio_pkg::P1_PU_IDX, fio_pkg::P0_FUNC_IDX};
    for (int i = 0; i < 7; i++) begin
      rchk("reset value", idx[i], 32'h0000_0000, 1'b0);
    end
    rchk("reset pin ctl", fio_pkg::P1_RSTCTL_IDX, 32'h0000_0001, 1'b0);
    chk("pin modes", 32'h0000_0000, {p1PinOe, p0PinOe});
    chk("reset pin mode", 32'h0000_0001, {31'h0, resetPinMode});
    chk("reset input", 32'h0000_0000, {31'h0, extResetIn});
    $display("test reset done");
  endtask

  task automatic t_port0;
    wr(fio_pkg::P0_DIR_IDX, 32'h0000_00FF);
    wr(fio_pkg::P0_LATCH_IDX, 32'h0000_00A5);
    rchk("latch0", fio_pkg::P0_LATCH_IDX, 32'h0000_0005, 1'b0);
    rchk("dir0", fio_pkg::P0_DIR_IDX, 32'h0000_000F, 1'b0);
    chk("p0 drive", 32'h0000_0F05, {p0PinOe, 4'h0, p0PinOut});
    rchk("read0 out", fio_pkg::P0_READ_IDX, 32'h0, 1'b0);
    p0Ext <= 4'hF;
    p0ExtEn <= 4'h9;
    wr(fio_pkg::P0_DIR_IDX, 32'h0000_0006);
    tick(3);
    chk("p0 oe mix", 32'h0000_0006, {28'h0, p0PinOe});
    rchk("read0 mix", fio_pkg::P0_READ_IDX, 32'h9, 1'b0);
    p0ExtEn <= 4'h0;
    wr(fio_pkg::P0_DIR_IDX, 32'h0000_0003);
    wr(fio_pkg::P0_PU_IDX, 32'h0000_000F);
    tick(3);
    chk("p0 pullup", 32'h0000_000C, {28'h0, p0PullupOn});
    rchk("read0 pull", fio_pkg::P0_READ_IDX, 32'hC, 1'b0);
    $display("test port zero done");
  endtask

  task automatic t_osc;
    wr(fio_pkg::P0_DIR_IDX, 32'h0000_0000);
    wr(fio_pkg::P0_FUNC_IDX, 32'h0000_00FF);
    rchk("func0", fio_pkg::P0_FUNC_IDX, 32'h0000_0005, 1'b0);
    chk("osc sel", 32'h0000_0011, {27'h0, lfOscPinSelect, 3'h0,
        hfOscPinSelect});
    wr(fio_pkg::P0_DIR_IDX, 32'h0000_000C);
    p0Ext <= 4'hF;
    p0ExtEn <= 4'h3;
    tick(3);
    chk("osc pads", 32'h0000_0000, {p0PinOe, p0PullupOn});
    rchk("read0 osc", fio_pkg::P0_READ_IDX, 32'h0, 1'b0);
    osc_try(1'b0);
    wr(fio_pkg::P0_FUNC_IDX, 32'h0000_0004);
    osc_try(1'b1);
    wr(fio_pkg::P0_DIR_IDX, 32'h0000_0000);
    tick(3);
    rchk("read0 lf", fio_pkg::P0_READ_IDX, 32'h3, 1'b0);
    wr(fio_pkg::P0_FUNC_IDX, 32'h0000_0000);
    $display("test oscillator done");
  endtask

  task automatic t_port1;
    p1Ext <= 4'h6;
    wr(fio_pkg::P1_RSTCTL_IDX, 32'h0000_0000);
    tick(3);
    chk("port mode", 32'h0, {31'h0, resetPinMode});
    rchk("read1 in", fio_pkg::P1_READ_IDX, 32'h6, 1'b0);
    chk("feeds", 32'h0000_1110, {15'h0, extIrqFive, 3'h0, stopReleaseIn,
        3'h0, extIrqZero, 3'h0, extIrqOne});
    wr(fio_pkg::P1_PU_IDX, 32'h0000_000F);
    tick(1);
    chk("p1 pullup in", 32'h0000_000F, {28'h0, p1PullupOn});
    wr(fio_pkg::P1_DIR_IDX, 32'h0000_000F);
    wr(fio_pkg::P1_LATCH_IDX, 32'h0000_00F9);
    rchk("latch1", fio_pkg::P1_LATCH_IDX, 32'h0000_0009, 1'b0);
    tick(2);
    chk("p1 drive", 32'h0000_0F09, {p1PinOe, p1PullupOn,
        p1PinOut});
    chk("feeds idle", 32'h0000_000F, {28'h0, extIrqFive, stopReleaseIn,
        extIrqZero, extIrqOne});
    rchk("read1 out", fio_pkg::P1_READ_IDX, 32'h0, 1'b0);
    rchk("unmapped", 16'h0100, 32'h0, 1'b1);
    $display("test port one done");
  endtask

  // Reset in mid-run: pin 0 of port one returns to reset-input duty
  task automatic t_rereset;
    @(posedge clk);
    resetn <= 1'b0;
    tick(3);
    chk("rerst mode", 32'h1, {31'h0, resetPinMode});
    @(posedge clk);
    resetn <= 1'b1;
    tick(2);
    rchk("rerst pin ctl", fio_pkg::P1_RSTCTL_IDX, 32'h1, 1'b0);
    rchk("rerst dir1", fio_pkg::P1_DIR_IDX, 32'h0, 1'b0);
    $display("test second reset done");
  endtask

  // ---------------------------------------------------------------
  // Verdict, clock, watchdog and main sequence
  // ---------------------------------------------------------------
  task automatic final_report;
    $display("Checks %0d mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Cuts a hang short well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    numErrors++;
    final_report();
  end

  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    externalHfOscEnable = 1'b0;
    p0Ext = 4'h0;
    p0ExtEn = 4'h0;
    p1Ext = 4'h0;
    p1ExtEn = 4'hF;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    tick(2);
    t_reset();
    t_port0();
    t_osc();
    t_port1();
    t_rereset();
    final_report();
  end
endmodule
